// file: rtl/peins_params.svh
// Constants of the payload error inserter: offsets, field positions,
// reset values and sizes.
// Assumes inclusion by bare name from the inserter's design files.
`ifndef PEINS_PARAMS_SVH
`define PEINS_PARAMS_SVH

// Register offsets on the byte-wide register port
`define PEINS_OFS_RATE     8'heb
`define PEINS_OFS_CNT_LO   8'hec
`define PEINS_OFS_CNT_HI   8'hed
`define PEINS_OFS_LEFT_LO  8'hee
`define PEINS_OFS_LEFT_HI  8'hef

// Field positions in the rate control register
`define PEINS_BIT_LOAD     7
`define PEINS_BIT_CONT     4
`define PEINS_RATE_MSB     3

// Reset values
`define PEINS_RST_BYTE     8'h00
`define PEINS_RST_CNT      10'h000

// Sizes
`define PEINS_CNT_W        10
`define PEINS_BITCNT_W     18
`define PEINS_RATE_BIAS    5'd3
`define PEINS_FIFO_DEPTH   4

`endif

// file: rtl/peins_pkg.sv
// Types of the payload error inserter.
// Assumes nothing beyond a SystemVerilog compiler.
package peins_pkg;

  // One transmit bit with its framer qualifiers
  typedef struct packed {
    logic sof;   // First bit of a frame
    logic fbit;  // Framing bit position
    logic chan;  // Bit lies in a selected channel
    logic data;  // Payload or framing bit value
  } peins_bit_type;

  // Insertion mode as derived from the control register
  typedef enum logic [1:0] {
    PEINS_OFF,
    PEINS_CONT,
    PEINS_COUNTED
  } peins_mode_type;

endpackage : peins_pkg

// file: rtl/peins_fifo_if.sv
// Bundle between the inserter core and its input FIFO.
// Assumes one clock domain shared by both ends.
`timescale 1ns/100ps
`default_nettype none

interface peins_fifo_if #(parameter int WIDTH = 4);
  logic             push_valid;  // Fill side offers a word
  logic             push_ready;  // FIFO has room
  logic [WIDTH-1:0] push_data;   // Word offered
  logic             pop_valid;   // FIFO holds a word
  logic             pop_ready;   // Drain side takes it
  logic [WIDTH-1:0] pop_data;    // Oldest word

  // FIFO end
  modport store (input push_valid, push_data, pop_ready,
                 output push_ready, pop_valid, pop_data);
  // Core end, filling and draining
  modport user (output push_valid, push_data, pop_ready,
                input push_ready, pop_valid, pop_data);
endinterface : peins_fifo_if

`default_nettype wire

// file: rtl/peins_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes a synchronous active-high reset on the shared clock.
`timescale 1ns/100ps
`default_nettype none

module peins_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 4
) (
  input  wire logic core_clk_i,  // Transmit clock
  input  wire logic rst_i,       // Synchronous reset
  peins_fifo_if.store ff         // Push and pop sides
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];  // Storage words
  logic [AW-1:0]    wr_ptr_r;       // Next write slot
  logic [AW-1:0]    rd_ptr_r;       // Oldest slot
  logic [AW:0]      fill_r;         // Words held
  logic             do_push;        // Write this cycle
  logic             do_pop;         // Read this cycle

  // Honest full and empty
  assign ff.push_ready = (fill_r != (AW+1)'(DEPTH));
  assign ff.pop_valid  = (fill_r != '0);
  assign ff.pop_data   = mem_r[rd_ptr_r];
  assign do_push       = ff.push_valid && ff.push_ready;
  assign do_pop        = ff.pop_valid && ff.pop_ready;

  // Storage write
  always_ff @(posedge core_clk_i) begin
    if (do_push) begin
      mem_r[wr_ptr_r] <= ff.push_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      fill_r   <= '0;
    end else begin
      if (do_push) wr_ptr_r <= AW'((wr_ptr_r + 1'b1) % DEPTH);
      if (do_pop)  rd_ptr_r <= AW'((rd_ptr_r + 1'b1) % DEPTH);
      fill_r <= fill_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule : peins_fifo

`default_nettype wire

// file: rtl/peins_top.sv
// Payload error inserter for the transmit T1 bit stream.
// Assumes the framer delivers one bit per handshake with frame-start,
// framing-bit and channel-select marks, all on the transmit clock.
// Behaviour
// R01: Corrupt payload only, whole frame or channels
// R02: Per-channel mode counts only selected channels
// R03: Invert the Nth counted bit at rate N
// R04: Framing bits never counted nor inverted
// R05: New rate takes effect at frame boundary
// R06: Code 0 none, else 1 in 2^(code+3)
// R07: Rate code zero inserts nothing, even continuous
// R08: Continuous mode ignores count, keeps inserting
// R09: Counted mode inserts loaded count, then stops
// R10: Load bit rising loads count next cycle
// R11: Host writes count before raising load bit
// R12: Host lowers load bit before each reload
// R13: Count is 10 bits over two registers
// R14: Zero count means no errors remaining
// R15: Remaining count readable any time, two registers
// R16: Host writes zero to unused bits 5, 6
// R17: Decrement remaining per error, stop at zero
// R18: Framer marks qualify which bits are counted
`include "peins_params.svh"
`timescale 1ns/100ps
`default_nettype none

module peins_top (
  input  wire logic                  core_clk_i,      // Transmit clock
  input  wire logic                  rst_i,           // Synchronous reset
  input  wire logic [7:0]            reg_addr_i,      // Register address
  input  wire logic [7:0]            reg_wdata_i,     // Write data
  input  wire logic                  reg_wr_i,        // Write strobe
  input  wire logic                  reg_rd_i,        // Read strobe
  output logic [7:0]                 reg_rdata_o,     // Read data, next cycle
  input  wire logic                  per_chan_mode_i, // Channel-select mode
  input  wire logic                  in_valid_i,      // Framer offers a bit
  output logic                       in_ready_o,      // Room to take it
  input  wire peins_pkg::peins_bit_type in_bit_i,     // Bit and its marks
  output logic                       out_valid_o,     // Bit ready to send
  input  wire logic                  out_ready_i,     // Line side takes it
  output peins_pkg::peins_bit_type   out_bit_o,       // Possibly inverted bit
  output logic                       out_err_o        // This bit was inverted
);
  import peins_pkg::*;

  // Register state
  logic [3:0]  rate_code_r;    // Written rate code
  logic        cont_r;         // Continuous insertion
  logic        load_r;         // Load-count strobe bit
  logic        load_d_r;       // Load bit one cycle ago
  logic [9:0]  count_r;        // Requested error count
  logic [9:0]  left_r;         // Errors still to insert
  logic [7:0]  rdata_r;        // Read data register

  // Stream state
  logic [3:0]  active_rate_r;  // Rate in force this frame
  logic [17:0] bit_cnt_r;      // Counted bits since last sequence end
  peins_bit_type out_bit_r;    // Output bit register
  logic        out_valid_r;    // Output holds a bit
  logic        out_err_r;      // Output bit was inverted

  // Combinational terms
  peins_bit_type  cur;         // Bit at FIFO head
  peins_mode_type mode;        // Current insertion mode
  logic        pop;            // Head bit processed now
  logic        load_go;        // Load rising edge seen
  logic        rate_chg;       // Frame start with new rate
  logic [3:0]  eff_rate;       // Rate applying to head bit
  logic [17:0] base;           // Count before head bit
  logic        counted;        // Head bit enters the count
  logic        hit;            // Head bit completes a sequence
  logic        allowed;        // Insertion still permitted
  logic        flip;           // Invert the head bit

  // Last count value of a rate sequence
  function automatic logic [17:0] rate_last(input logic [3:0] code);
    logic [18:0] span;
    span = 19'h1 << (5'(code) + `PEINS_RATE_BIAS);  // R06
    return 18'(span - 19'h1);
  endfunction : rate_last

  // Input FIFO between framer and inserter
  peins_fifo_if #(.WIDTH($bits(peins_bit_type))) ff ();

  peins_fifo #(
    .WIDTH ($bits(peins_bit_type)),
    .DEPTH (`PEINS_FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ff         (ff.store)
  );

  // Framer side of the FIFO
  assign ff.push_valid = in_valid_i;
  assign ff.push_data  = in_bit_i;
  assign in_ready_o    = ff.push_ready;

  // Drain when the output register is free or leaving
  assign cur          = ff.pop_data;
  assign ff.pop_ready = !out_valid_r || out_ready_i;
  assign pop          = ff.pop_valid && ff.pop_ready;

  // Register writes: rate control
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rate_code_r <= 4'h0;
      cont_r      <= 1'b0;
      load_r      <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == `PEINS_OFS_RATE) begin
      rate_code_r <= reg_wdata_i[`PEINS_RATE_MSB:0];
      cont_r      <= reg_wdata_i[`PEINS_BIT_CONT];
      load_r      <= reg_wdata_i[`PEINS_BIT_LOAD];
    end
  end

  // Register writes: requested count, two halves
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      count_r <= `PEINS_RST_CNT;
    end else if (reg_wr_i && reg_addr_i == `PEINS_OFS_CNT_LO) begin
      count_r[7:0] <= reg_wdata_i;  // R13
    end else if (reg_wr_i && reg_addr_i == `PEINS_OFS_CNT_HI) begin
      count_r[9:8] <= reg_wdata_i[1:0];  // R13
    end
  end

  // Load bit history for edge detection
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      load_d_r <= 1'b0;
    end else begin
      load_d_r <= load_r;
    end
  end

  // Only a fresh zero-to-one change reloads
  assign load_go = load_r && !load_d_r;  // R10 R12

  // Insertion mode from control bits
  always_comb begin
    if (eff_rate == 4'h0) begin
      mode = PEINS_OFF;  // R07
    end else if (cont_r) begin
      mode = PEINS_CONT;  // R08
    end else begin
      mode = PEINS_COUNTED;  // R09
    end
  end

  // Continuous mode ignores the count; counted needs some left
  assign allowed = (mode == PEINS_CONT) ||
                   (mode == PEINS_COUNTED && left_r != 10'h000);  // R08 R09 R14

  // Remaining-count register
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      left_r <= `PEINS_RST_CNT;
    end else if (load_go) begin
      left_r <= count_r;  // R10
    end else if (flip && mode == PEINS_COUNTED) begin
      left_r <= left_r - 10'h001;  // R17
    end
  end

  // Rate swaps in only at the first bit of a frame
  assign rate_chg = pop && cur.sof && (rate_code_r != active_rate_r);  // R05
  assign eff_rate = (pop && cur.sof) ? rate_code_r : active_rate_r;  // R05

  // Latch the rate at each frame start
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      active_rate_r <= 4'h0;
    end else if (pop && cur.sof) begin
      active_rate_r <= rate_code_r;  // R05
    end
  end

  // Which bits enter the count
  assign counted = pop && !cur.fbit &&  // R04
                   (!per_chan_mode_i || cur.chan) &&  // R01 R02 R18
                   (eff_rate != 4'h0);  // R07
  assign base    = rate_chg ? 18'h0 : bit_cnt_r;
  assign hit     = counted && (base == rate_last(eff_rate));  // R03 R06
  assign flip    = hit && allowed;  // R03 R09

  // Bit counter of the running sequence
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      bit_cnt_r <= 18'h0;
    end else if (hit) begin
      bit_cnt_r <= 18'h0;  // R03
    end else if (counted) begin
      bit_cnt_r <= base + 18'h1;
    end else if (rate_chg) begin
      bit_cnt_r <= 18'h0;
    end
  end

  // Output register, holds until taken
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      out_valid_r <= 1'b0;
      out_bit_r   <= '0;
      out_err_r   <= 1'b0;
    end else if (pop) begin
      out_valid_r    <= 1'b1;
      out_bit_r      <= cur;
      out_bit_r.data <= cur.data ^ flip;  // R01 R03
      out_err_r      <= flip;
    end else if (out_ready_i) begin
      out_valid_r <= 1'b0;
      out_err_r   <= 1'b0;
    end
  end

  assign out_valid_o = out_valid_r;
  assign out_bit_o   = out_bit_r;
  assign out_err_o   = out_err_r;

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !reg_rd_i) begin
      rdata_r <= `PEINS_RST_BYTE;
    end else if (reg_addr_i == `PEINS_OFS_RATE) begin
      rdata_r <= {load_r, 2'b00, cont_r, rate_code_r};
    end else if (reg_addr_i == `PEINS_OFS_CNT_LO) begin
      rdata_r <= count_r[7:0];
    end else if (reg_addr_i == `PEINS_OFS_CNT_HI) begin
      rdata_r <= {6'h00, count_r[9:8]};
    end else if (reg_addr_i == `PEINS_OFS_LEFT_LO) begin
      rdata_r <= left_r[7:0];  // R15
    end else if (reg_addr_i == `PEINS_OFS_LEFT_HI) begin
      rdata_r <= {6'h00, left_r[9:8]};  // R15
    end else begin
      rdata_r <= `PEINS_RST_BYTE;  // Unmapped reads zero
    end
  end

  assign reg_rdata_o = rdata_r;

  // Checks on the inserter's behaviour
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // Framing bits pass unchanged
  a_fbit_untouched: assert property ( // R04
    pop && cur.fbit |=> out_bit_o.data == $past(cur.data) && !out_err_o)
    else $error("framing bit was altered");

  // Unselected channels pass unchanged
  a_chan_select: assert property ( // R02
    pop && per_chan_mode_i && !cur.chan |=> !out_err_o)
    else $error("bit outside selected channels altered");

  // Zero rate inserts nothing
  a_rate_zero: assert property ( // R07
    pop && eff_rate == 4'h0 |=> !out_err_o)
    else $error("error inserted at rate zero");

  // Flip only on the last bit of a sequence
  a_nth_bit: assert property ( // R03
    flip |-> counted && (19'(base) + 19'h1) == (19'h1 << (5'(eff_rate) + 5'd3)))
    else $error("flip not on sequence end");

  // Rate in force stays put inside a frame
  a_rate_frame: assert property ( // R05
    !(pop && cur.sof) |=> $stable(active_rate_r))
    else $error("rate changed inside a frame");

  // Count loads one cycle after the bit rises
  a_load_next: assert property ( // R10
    $rose(load_r) |=> left_r == $past(count_r))
    else $error("count not loaded after rising load bit");

  // Counted mode decrements by exactly one
  a_left_dec: assert property ( // R17
    flip && mode == PEINS_COUNTED && !load_go |=> left_r == $past(left_r) - 10'h001)
    else $error("remaining count not decremented");

  // Nothing inserted once the count is spent
  a_stop_zero: assert property ( // R09
    !cont_r && left_r == 10'h000 |-> !flip)
    else $error("error inserted with none left");

  // Continuous mode leaves the count alone
  a_cont_keep: assert property ( // R08
    cont_r && !load_go |=> left_r == $past(left_r))
    else $error("count moved in continuous mode");

  // Remaining count read back a cycle later
  a_read_left: assert property ( // R15
    reg_rd_i && reg_addr_i == `PEINS_OFS_LEFT_LO |=> reg_rdata_o == $past(left_r[7:0]))
    else $error("remaining count read back wrong");

  // Read data drop to zero after the read cycle
  a_read_once: assert property (
    !reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data stood too long");

  // Inversion mark matches the data change
  a_flip_marked: assert property ( // R03
    pop |=> out_err_o == (out_bit_o.data != $past(cur.data)))
    else $error("error mark does not match inversion");

  // Output bit waits unchanged for the sink
  a_out_hold: assert property (
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_bit_o) && $stable(out_err_o))
    else $error("output bit changed before taken");

  // Frame start takes the written rate
  a_rate_apply: assert property ( // R05
    pop && cur.sof |=> active_rate_r == $past(rate_code_r))
    else $error("rate not taken at frame start");

  // Continuous mode inverts every sequence end
  a_cont_flip: assert property ( // R08
    hit && mode == PEINS_CONT |-> flip)
    else $error("continuous mode skipped an error");

  // Loading a zero count leaves nothing to insert
  a_load_zero: assert property ( // R14
    load_go && count_r == 10'h000 |=> left_r == 10'h000)
    else $error("zero count left errors pending");

  // Upper count half reads back in place
  a_read_count: assert property ( // R13
    reg_rd_i && reg_addr_i == `PEINS_OFS_CNT_HI |=> reg_rdata_o == {6'h00, $past(count_r[9:8])})
    else $error("count read back wrong");

  // Unused control bits always read zero
  a_read_unused: assert property (
    reg_rd_i && reg_addr_i == `PEINS_OFS_RATE |=> reg_rdata_o[6:5] == 2'b00)
    else $error("unused control bits read nonzero");

  // Main scenarios
  c_cont_flip:   cover property (flip && mode == PEINS_CONT);
  c_chan_flip:   cover property (flip && per_chan_mode_i);
  c_count_flip:  cover property (flip && mode == PEINS_COUNTED);
  c_count_spent: cover property (flip && left_r == 10'h001 && !cont_r);
  c_rate_swap:   cover property (rate_chg);

endmodule : peins_top

`default_nettype wire

// file: dv/peins_framer_model.sv
// Transmit framer and line sink standing beside the payload error inserter.
// Assumes one transmit clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none

module peins_framer_model #(
  parameter int FRAME_BITS = 193  // F-bit plus 24 channels of 8 bits
) (
  input  wire logic              core_clk_i,   // Transmit clock
  input  wire logic              rst_i,        // Synchronous reset
  input  wire logic              run_i,        // Keep offering bits
  input  wire logic              stall_i,      // Sink refuses bits
  output logic                   valid_o,      // Bit offered
  input  wire logic              ready_i,      // Inserter takes it
  output peins_pkg::peins_bit_type bit_o,      // Bit with framer marks
  output logic                   sink_ready_o  // Sink takes output bit
);
  import peins_pkg::*;

  logic [7:0] pos_r;  // Frame position of the offered bit
  logic [7:0] ch_r;   // Position less one, channel in bits 7:3

  // Offer held until taken; position advances per handshake
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
      pos_r   <= 8'h00;
    end else begin
      if (valid_o && ready_i) begin
        pos_r <= (pos_r == 8'(FRAME_BITS - 1)) ? 8'h00 : pos_r + 8'h01;
      end
      if (!valid_o || ready_i) begin
        valid_o <= run_i;
      end
    end
  end

  // Marks: F-bit first, odd channels selected, F-bit data high
  assign ch_r       = pos_r - 8'h01;
  assign bit_o.sof  = (pos_r == 8'h00);
  assign bit_o.fbit = (pos_r == 8'h00);
  assign bit_o.chan = (pos_r != 8'h00) && ch_r[3];
  assign bit_o.data = (pos_r == 8'h00);
  assign sink_ready_o = !stall_i;
endmodule : peins_framer_model

`default_nettype wire

// file: dv/peins_top_bench.sv
// Self-checking bench for the payload error inserter.
// Assumes the framer model beside it and a 200 MHz transmit clock.
`include "peins_params.svh"
`timescale 1ns/100ps
`default_nettype none

module peins_top_bench;
  import peins_pkg::*;

  logic          clk, rst, wr, rd, pc;    // Clock, reset, strobes, mode
  logic          run, stall, iv, ir;      // Model controls, input side
  logic          ov, ordy, oerr;          // Output side
  logic [7:0]    addr, wd, rdat;          // Register port
  peins_bit_type ib, ob;                  // Stream bits
  int            mismatches = 0;          // Failed comparisons
  int            num_checks = 0;          // All comparisons
  int            opos = 0;                // Expected output position
  int            since = 0;               // Counted bits since last error
  int            nerr = 0;                // Errors seen
  int            e0;                      // Error mark
  bit            have = 0;                // Spacing reference exists
  bit            sp_on = 0;               // Spacing check enabled
  logic [3:0]    cur_rate = 4'h0;         // Rate in force at output
  logic [3:0]    pend_rate = 4'h0;        // Last rate written

  peins_top i_dut (.core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .per_chan_mode_i(pc), .in_valid_i(iv),
    .in_ready_o(ir), .in_bit_i(ib), .out_valid_o(ov), .out_ready_i(ordy), .out_bit_o(ob),
    .out_err_o(oerr));
  peins_framer_model i_frm (.core_clk_i(clk), .rst_i(rst), .run_i(run), .stall_i(stall),
    .valid_o(iv), .ready_i(ir), .bit_o(ib), .sink_ready_o(ordy));

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One-cycle register write
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd   <= d;
    wr   <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    if (a == `PEINS_OFS_RATE) pend_rate = d[3:0];
  endtask : wr_reg

  // One-cycle read, data checked in the following cycle
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdat, exp);
  endtask : rd_chk

  // Let n bits enter, then stop and drain
  task automatic run_bits(input int n);
    int k;
    k = 0;
    run <= 1'b1;
    while (k < n) begin
      @(posedge clk);
      if (iv && ir) k++;
    end
    run <= 1'b0;
    repeat (20) @(posedge clk);
  endtask : run_bits

  task automatic done(input string name);
    $display("test %s done", name);
  endtask : done

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  // Output monitor: marks, inversion, error placement and spacing
  always @(posedge clk) begin
    if (rst) begin
      opos = 0;
    end else if (ov && ordy) begin
      if (opos == 0 && pend_rate !== cur_rate) begin
        cur_rate = pend_rate;
        since = 0;
        have = (cur_rate != 4'h0);
      end
      chk({ob.sof, ob.fbit, ob.chan}, {opos == 0, opos == 0, opos != 0 && ((opos - 1) & 8) != 0});
      chk(oerr, ob.data ^ (opos == 0));
      if (ob.fbit) chk(ob.data, 1'b1);
      if (!ob.fbit && (ob.chan || !pc)) since++;
      if (oerr) begin
        chk(!ob.fbit && (ob.chan || !pc), 1'b1);
        if (have && sp_on) chk(since, 32'd1 << (cur_rate + 3));
        have = 1'b1;
        since = 0;
        nerr++;
      end
      opos = (opos == 192) ? 0 : opos + 1;
    end
  end

  // Clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end

  // Test sequence
  initial begin
    rst = 1'b1;
    addr = 8'h00;
    wd = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    pc = 1'b0;
    run = 1'b0;
    stall = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int a = 8'heb; a <= 8'hef; a++) rd_chk(8'(a), 8'h00);
    wr_reg(`PEINS_OFS_LEFT_LO, 8'h5a);
    wr_reg(8'hea, 8'h5a);
    rd_chk(`PEINS_OFS_LEFT_LO, 8'h00);
    rd_chk(8'hea, 8'h00);
    for (int r = 0; r < 16; r++) begin
      wr_reg(`PEINS_OFS_RATE, 8'(r));
      rd_chk(`PEINS_OFS_RATE, 8'(r));
    end
    wr_reg(`PEINS_OFS_CNT_LO, 8'hff);
    wr_reg(`PEINS_OFS_CNT_HI, 8'h03);
    wr_reg(`PEINS_OFS_RATE, 8'h80);
    rd_chk(`PEINS_OFS_LEFT_LO, 8'hff);
    rd_chk(`PEINS_OFS_LEFT_HI, 8'h03);
    rd_chk(`PEINS_OFS_CNT_HI, 8'h03);
    wr_reg(`PEINS_OFS_CNT_LO, 8'h05);
    wr_reg(`PEINS_OFS_CNT_HI, 8'h00);
    wr_reg(`PEINS_OFS_RATE, 8'h80);
    rd_chk(`PEINS_OFS_LEFT_HI, 8'h03);
    wr_reg(`PEINS_OFS_RATE, 8'h10);
    wr_reg(`PEINS_OFS_RATE, 8'h90);
    rd_chk(`PEINS_OFS_LEFT_LO, 8'h05);
    wr_reg(`PEINS_OFS_RATE, 8'h10);
    done("registers");
    // Rate zero with constant insertion, stop mid-frame
    run_bits(100 + 2 * 193);
    chk(nerr, 0);
    done("rate zero");
    // Constant insertion, rate changed mid-frame
    sp_on = 1'b1;
    for (int r = 1; r < 5; r++) begin
      wr_reg(`PEINS_OFS_RATE, 8'h10 | 8'(r));
      run_bits(4 * 193);
    end
    chk(nerr != 0, 1'b1);
    rd_chk(`PEINS_OFS_LEFT_LO, 8'h05);
    done("constant");
    // Selected channels only
    pc <= 1'b1;
    wr_reg(`PEINS_OFS_RATE, 8'h11);
    e0 = nerr;
    run_bits(3 * 193);
    chk(nerr > e0, 1'b1);
    pc <= 1'b0;
    done("channels");
    // Counted insertion, then a zero count
    sp_on = 1'b0;
    wr_reg(`PEINS_OFS_CNT_LO, 8'h03);
    wr_reg(`PEINS_OFS_RATE, 8'h01);
    wr_reg(`PEINS_OFS_RATE, 8'h81);
    e0 = nerr;
    run_bits(2 * 193);
    chk(nerr - e0, 3);
    rd_chk(`PEINS_OFS_LEFT_LO, 8'h00);
    wr_reg(`PEINS_OFS_RATE, 8'h01);
    wr_reg(`PEINS_OFS_CNT_LO, 8'h00);
    wr_reg(`PEINS_OFS_RATE, 8'h81);
    e0 = nerr;
    run_bits(193);
    chk(nerr - e0, 0);
    done("counted");
    // Fill the FIFO against a stalled sink, then drain
    stall <= 1'b1;
    run <= 1'b1;
    repeat (20) @(posedge clk);
    chk(ir, 1'b0);
    chk(ov, 1'b1);
    stall <= 1'b0;
    run <= 1'b0;
    repeat (30) @(posedge clk);
    chk({ir, ov}, 2'b10);
    done("fifo");
    report_and_stop();
  end
endmodule : peins_top_bench

`default_nettype wire
